// ---- design/sram_port_pkg.sv ----
// shared constants, types and pin bundle for the burst sram host controller
package sram_port_pkg;

   // data port geometry: four nine-bit lanes, four words per burst
   localparam int DATA_W = 36;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int ADDR_W = 19;
   localparam int BURST_LEN = 4;

   // clocking: the input clock pair is ref_clk divided by four
   localparam int REF_PERIOD_NS = 20;
   localparam int REF_MHZ = 1000 / REF_PERIOD_NS;
   localparam int K_DIV = 4;
   localparam int K_MHZ = REF_MHZ / K_DIV;
   localparam int DLL_MIN_MHZ = 120;
   localparam logic DLL_USABLE = (K_MHZ >= DLL_MIN_MHZ);

   // phase counter values marking the launch edges and the edges that raise and lower k
   localparam logic [1:0] PH_K_RISE_LAUNCH = 2'h2;
   localparam logic [1:0] PH_K_FALL_LAUNCH = 2'h0;
   localparam logic [1:0] PH_K_GOES_HIGH = 2'h3;
   localparam logic [1:0] PH_K_GOES_LOW = 2'h1;

   // waits, in input clock periods except the power-up and stop waits, which count reference cycles
   localparam int POWER_STABLE_CYC = 1000;
   localparam int LOCK_K_CYC = 2048;
   localparam int RESTART_K_CYC = 1024;
   localparam int ZQ_NONREAD_K_CYC = 1024;
   localparam int STOP_MIN_NS = 30;
   localparam int STOP_MIN_CYC = (STOP_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

   // read return: k periods from read launch to the first echo pair
   localparam int RD_LAT_K = 2;

   // output clock strap, fixed from power-up
   localparam logic SINGLE_CLOCK_MODE = 1'b0;

   // idle values
   localparam logic [LANES-1:0] LANES_OFF = 4'hf;
   localparam logic [DATA_W-1:0] DATA_IDLE = 36'h0_0000_0000;

   typedef logic [DATA_W-1:0] word_t;
   typedef logic [BURST_LEN-1:0][DATA_W-1:0] burst_t;
   typedef logic [1:0][DATA_W-1:0] pair_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      burst_t data;
      logic [BURST_LEN-1:0][LANES-1:0] byte_write_select_n;
   } wr_req_s;

   typedef struct packed {
      logic k;
      logic k_n;
      logic c;
      logic c_n;
      logic dll_disable_n;
      logic read_select_n;
      logic write_select_n;
      logic [ADDR_W-1:0] shared_address_bus;
      word_t write_data;
      logic [LANES-1:0] byte_write_select_n;
   } sram_pins_s;

   localparam sram_pins_s PINS_RESET = '{
      k: 1'b0, k_n: 1'b1, c: SINGLE_CLOCK_MODE, c_n: 1'b1,
      dll_disable_n: 1'b0, read_select_n: 1'b1, write_select_n: 1'b1,
      shared_address_bus: '0, write_data: DATA_IDLE,
      byte_write_select_n: LANES_OFF};

   typedef enum {
      ST_POWER, ST_LOCK, ST_ZQ, ST_RUN, ST_DRAIN, ST_STOP, ST_RESTART
   } init_state_e;

endpackage : sram_port_pkg

// ---- design/bit_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
module bit_sync (
   // destination clock
   input wire logic clk_in,
   // level from another domain
   input wire logic d_in,
   // synchronised level
   output logic q_out
);
   logic meta;

   // first stage feeds only the second
   always_ff @(posedge clk_in) begin
      meta <= d_in;
      q_out <= meta;
   end
endmodule : bit_sync

// ---- design/echo_capture.sv ----
// read data capture on the echo clock, published as word pairs
`timescale 1ns/1ps
module echo_capture (
   // echo clock domain
   input wire logic echo_clock_in,
   input wire logic rst_in,
   input wire sram_port_pkg::word_t read_data_in,
   // pair handed to the reference domain
   output sram_port_pkg::pair_t pair_out,
   output logic pair_toggle_out
);
   import sram_port_pkg::*;

   logic rst_echo;
   word_t first_word;

   // reset brought into the echo domain
   bit_sync u_rst_sync (
      .clk_in(echo_clock_in),
      .d_in(rst_in),
      .q_out(rst_echo)
   );

   // first word of a pair arrives on the falling echo edge
   always_ff @(negedge echo_clock_in) begin
      first_word <= read_data_in;
   end

   // pair stays put for one whole echo period, long enough for the toggle
   always_ff @(posedge echo_clock_in) begin
      pair_out <= {read_data_in, first_word};
      if (rst_echo) begin
         pair_toggle_out <= 1'b0;
      end else begin
         pair_toggle_out <= ~pair_toggle_out;
      end
   end
endmodule : echo_capture

// ---- design/sram_port_host.sv ----
// host controller driving a burst-of-four double rate sram over its pins
//
// Behaviour
// - a read is one cycle of read select low at an input clock rise.
// - single clock mode means output clock pins high from power-up, never changed.
// - a write is one cycle of write select low at an input clock rise.
// - read and write addresses share one bus on alternate input clock rises.
// - write words follow at next rise, then fall, rise, fall edges.
// - after power-up, 1024 cycles without reads before relying on impedance.
// - after a clock stop, 1024 cycles before normal use again.
// - dll disable held low until supplies and clock are stable.
// - 2048 input clock cycles for dll lock before normal commands.
// - clock stopped at least 30 ns to reset the dll.
// - dll only enabled with the input clock at or above 120 mhz.
// - a frequency change needs a dll reset and 2048 cycles again.
// - no reads, nor writes, on consecutive input clock rises.
`timescale 1ns/1ps
module sram_port_host (
   // reference clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // power and clock control
   input wire logic clock_stop_req_in,
   input wire logic dll_reset_req_in,
   output logic link_ready_out,
   output logic clock_stopped_out,
   // read requests and answers
   input wire logic rd_valid_in,
   input wire logic [sram_port_pkg::ADDR_W-1:0] rd_addr_in,
   output logic rd_ready_out,
   output logic rd_resp_valid_out,
   output sram_port_pkg::burst_t rd_data_out,
   // write requests
   input wire logic wr_valid_in,
   input wire sram_port_pkg::wr_req_s wr_req_in,
   output logic wr_ready_out,
   // sram pins
   output sram_port_pkg::sram_pins_s sram_out,
   input wire logic echo_clock_in,
   input wire sram_port_pkg::word_t read_data_in
);
   import sram_port_pkg::*;

   init_state_e state;
   init_state_e next_state;
   logic [1:0] ph;
   logic [15:0] cnt;
   logic slot;
   logic relock;
   logic rd_take;
   logic wr_take;
   logic launch_rise;
   logic half_edge;
   logic drained;
   logic next_k;
   logic [5:1] q_v;
   word_t q_d [1:5];
   logic [LANES-1:0] q_bw [1:5];
   logic [RD_LAT_K+1:0] rd_tag;
   pair_t echo_pair;
   logic echo_toggle;
   logic toggle_sync;
   logic toggle_seen;
   logic pair_evt;

   // interval load for each state, in the unit that state counts
   function automatic logic [15:0] wait_for(input init_state_e s);
      logic [15:0] w;
      w = 16'h0000;
      case (s)
         ST_POWER: w = 16'(POWER_STABLE_CYC);
         ST_LOCK: w = 16'(LOCK_K_CYC);
         ST_ZQ: w = 16'(ZQ_NONREAD_K_CYC);
         ST_STOP: w = 16'(STOP_MIN_CYC);
         ST_RESTART: w = 16'(RESTART_K_CYC);
         default: w = 16'h0000;
      endcase
      return w;
   endfunction : wait_for

   // handshakes close only in the second cycle before an input clock rise
   assign rd_take = rd_valid_in && rd_ready_out;
   assign wr_take = wr_valid_in && wr_ready_out;
   assign launch_rise = (ph == PH_K_RISE_LAUNCH);
   assign half_edge = (ph == PH_K_RISE_LAUNCH) || (ph == PH_K_FALL_LAUNCH);

   // nothing in flight and no handshake about to close
   assign drained = !(|q_v) && !(|rd_tag) && !rd_ready_out && !wr_ready_out;

   // divider phase: one increment per reference cycle, four per k period
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ph <= 2'h0;
      end else begin
         ph <= ph + 2'h1;
      end
   end

   // state sequencing for power-up, lock, stop and restart
   always_comb begin
      next_state = state;
      case (state)
         ST_POWER: begin
            if (cnt == 16'h0000) begin
               next_state = ST_LOCK;
            end
         end
         ST_LOCK: begin
            if (cnt == 16'h0000) begin
               next_state = ST_ZQ;
            end
         end
         ST_ZQ: begin
            if (cnt == 16'h0000) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (clock_stop_req_in || dll_reset_req_in) begin
               next_state = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // stop only on the edge that lowers k, so no runt pulse goes out
            if (drained && (ph == PH_K_GOES_LOW)) begin
               next_state = ST_STOP;
            end
         end
         ST_STOP: begin
            if ((cnt == 16'h0000) && !clock_stop_req_in) begin
               next_state = relock ? ST_LOCK : ST_RESTART;
            end
         end
         ST_RESTART: begin
            if (cnt == 16'h0000) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_POWER;
         end
      endcase
   end

   // state register
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state <= ST_POWER;
      end else begin
         state <= next_state;
      end
   end

   // interval counter: reference cycles while powering or stopped, else k periods
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cnt <= wait_for(ST_POWER);
      end else if (state != next_state) begin
         cnt <= wait_for(next_state);
      end else if ((cnt != 16'h0000) &&
                   ((state == ST_POWER) || (state == ST_STOP) || launch_rise)) begin
         cnt <= cnt - 16'h0001;
      end
   end

   // remember a dll reset request until relocking starts
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         relock <= 1'b0;
      end else if ((state == ST_RUN) && dll_reset_req_in) begin
         relock <= 1'b1;
      end else if (state == ST_LOCK) begin
         relock <= 1'b0;
      end
   end

   // read and write slots alternate per k rise, spacing each kind two rises apart
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         slot <= 1'b0;
      end else if (launch_rise) begin
         slot <= ~slot;
      end
   end

   // ready rises for exactly the one cycle before a k rise launch
   // judged on next_state so a slot never opens as link_ready_out drops
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rd_ready_out <= 1'b0;
         wr_ready_out <= 1'b0;
      end else begin
         rd_ready_out <= (ph == PH_K_GOES_LOW) && !slot && (next_state == ST_RUN);
         wr_ready_out <= (ph == PH_K_GOES_LOW) && slot &&
                         ((next_state == ST_RUN) || (next_state == ST_ZQ));
      end
   end

   // k level for the next cycle; parked low while stopped
   always_comb begin
      next_k = sram_out.k;
      if (next_state == ST_STOP || state == ST_STOP) begin
         next_k = 1'b0;
      end else if (ph == PH_K_GOES_HIGH) begin
         next_k = 1'b1;
      end else if (ph == PH_K_GOES_LOW) begin
         next_k = 1'b0;
      end
   end

   // clock pins; c pair mirrors k, or sits high in single clock mode
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sram_out.k <= PINS_RESET.k;
         sram_out.k_n <= PINS_RESET.k_n;
         sram_out.c <= PINS_RESET.c;
         sram_out.c_n <= PINS_RESET.c_n;
      end else begin
         sram_out.k <= next_k;
         sram_out.k_n <= ~next_k;
         sram_out.c <= SINGLE_CLOCK_MODE | next_k;
         sram_out.c_n <= SINGLE_CLOCK_MODE | ~next_k;
      end
   end

   // dll stays off until power is settled, and for good below its floor
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sram_out.dll_disable_n <= PINS_RESET.dll_disable_n;
      end else begin
         sram_out.dll_disable_n <= (state != ST_POWER) && DLL_USABLE;
      end
   end

   // command and address launch, one reference cycle (a quarter k period) ahead of the rise
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sram_out.read_select_n <= PINS_RESET.read_select_n;
         sram_out.write_select_n <= PINS_RESET.write_select_n;
         sram_out.shared_address_bus <= PINS_RESET.shared_address_bus;
      end else if (launch_rise) begin
         sram_out.read_select_n <= ~rd_take;
         sram_out.write_select_n <= ~wr_take;
         if (rd_take) begin
            sram_out.shared_address_bus <= rd_addr_in;
         end else if (wr_take) begin
            sram_out.shared_address_bus <= wr_req_in.addr;
         end
      end
   end

   // write word queue: a taken write lands two half periods out, one word per edge
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         q_v <= 5'h00;
         for (int i = 1; i <= 5; i++) begin
            q_d[i] <= DATA_IDLE;
            q_bw[i] <= LANES_OFF;
         end
      end else if (half_edge) begin
         for (int i = 1; i < 5; i++) begin
            q_v[i] <= q_v[i+1];
            q_d[i] <= q_d[i+1];
            q_bw[i] <= q_bw[i+1];
         end
         q_v[5] <= 1'b0;
         q_d[5] <= DATA_IDLE;
         q_bw[5] <= LANES_OFF;
         if (wr_take) begin
            // the earlier burst still holds slot 1, so the new one starts behind it
            for (int b = 0; b < BURST_LEN; b++) begin
               q_v[b+2] <= 1'b1;
               q_d[b+2] <= wr_req_in.data[b];
               q_bw[b+2] <= wr_req_in.byte_write_select_n[b];
            end
         end
      end
   end

   // write data pins; lanes masked off between bursts
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sram_out.write_data <= PINS_RESET.write_data;
         sram_out.byte_write_select_n <= PINS_RESET.byte_write_select_n;
      end else if (half_edge) begin
         sram_out.write_data <= q_v[1] ? q_d[1] : DATA_IDLE;
         sram_out.byte_write_select_n <= q_v[1] ? q_bw[1] : LANES_OFF;
      end
   end

   // read tracking: one tag bit per k period since launch
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rd_tag <= '0;
      end else if (launch_rise) begin
         rd_tag <= {rd_tag[RD_LAT_K:0], rd_take};
      end
   end

   // echo domain capture of word pairs
   echo_capture u_echo (
      .echo_clock_in(echo_clock_in),
      .rst_in(rst_in),
      .read_data_in(read_data_in),
      .pair_out(echo_pair),
      .pair_toggle_out(echo_toggle)
   );

   // pair toggle brought over; the pair itself is stable by the time it is seen
   bit_sync u_toggle_sync (
      .clk_in(ref_clk_in),
      .d_in(echo_toggle),
      .q_out(toggle_sync)
   );

   // edge detect on the synchronised toggle
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         toggle_seen <= 1'b0;
      end else begin
         toggle_seen <= toggle_sync;
      end
   end
   assign pair_evt = (toggle_sync != toggle_seen);

   // assemble two echo pairs into one four-word answer
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rd_resp_valid_out <= 1'b0;
         rd_data_out <= '0;
      end else begin
         rd_resp_valid_out <= 1'b0;
         if (pair_evt && rd_tag[RD_LAT_K]) begin
            rd_data_out[1:0] <= echo_pair;
         end
         if (pair_evt && rd_tag[RD_LAT_K+1]) begin
            rd_data_out[3:2] <= echo_pair;
            rd_resp_valid_out <= 1'b1;
         end
      end
   end

   // status levels for the user side
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         link_ready_out <= 1'b0;
         clock_stopped_out <= 1'b0;
      end else begin
         link_ready_out <= (next_state == ST_RUN);
         clock_stopped_out <= (next_state == ST_STOP);
      end
   end

endmodule : sram_port_host

// ---- testbench/sram_port_host_monitor.sv ----
// port checker for the burst sram host controller
`timescale 1ns/1ps
module sram_port_host_monitor (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // status
   input wire logic link_ready_out,
   input wire logic clock_stopped_out,
   // requests
   input wire logic rd_valid_in,
   input wire logic [sram_port_pkg::ADDR_W-1:0] rd_addr_in,
   input wire logic rd_ready_out,
   input wire logic rd_resp_valid_out,
   input wire logic wr_valid_in,
   input wire sram_port_pkg::wr_req_s wr_req_in,
   input wire logic wr_ready_out,
   // pins
   input wire sram_port_pkg::sram_pins_s sram_out
);
   import sram_port_pkg::*;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   // accepted requests and the beat on the write pins
   wire logic rd_take = rd_ready_out && rd_valid_in;
   wire logic wr_take = wr_ready_out && wr_valid_in;
   wire logic [DATA_W+LANES-1:0] pin_beat = {sram_out.write_data, sram_out.byte_write_select_n};

   function automatic logic [DATA_W+LANES-1:0] beat_of(input wr_req_s r, input int i);
      return {r.data[i], r.byte_write_select_n[i]};
   endfunction : beat_of

   // beats hold two ref cycles; word0 lands four edges after the take
   sequence s_wr_first;
      ##5 (pin_beat == beat_of($past(wr_req_in, 5), 0)) ##2 (pin_beat == beat_of($past(wr_req_in, 7), 1));
   endsequence
   sequence s_wr_last;
      (pin_beat == beat_of($past(wr_req_in, 9), 2)) ##2 (pin_beat == beat_of($past(wr_req_in, 11), 3));
   endsequence

   a_read_spacing: assert property (rd_ready_out |=> !rd_ready_out [*7])
      else $error("read slots closer than two k periods");
   a_write_spacing: assert property (wr_ready_out |=> !wr_ready_out [*7])
      else $error("write slots closer than two k periods");
   a_slots_apart: assert property (rd_ready_out |-> !wr_ready_out)
      else $error("read and write slot offered together");
   a_read_launch: assert property (rd_take |=> !sram_out.read_select_n &&
      sram_out.shared_address_bus == $past(rd_addr_in)) else $error("read not launched");
   a_write_launch: assert property (wr_take |=> !sram_out.write_select_n &&
      sram_out.shared_address_bus == $past(wr_req_in.addr)) else $error("write not launched");
   a_write_words: assert property (wr_take |-> s_wr_first ##2 s_wr_last)
      else $error("write beats out of order");
   a_read_answer: assert property (rd_take |-> ##[6:30] rd_resp_valid_out)
      else $error("read answer missing");
   a_ready_in_run: assert property (rd_ready_out |-> link_ready_out)
      else $error("read offered before run");
   a_dll_off: assert property (!DLL_USABLE |-> !sram_out.dll_disable_n)
      else $error("dll enabled below its floor");
   a_clock_parked: assert property (clock_stopped_out |-> !sram_out.k &&
      sram_out.read_select_n && sram_out.write_select_n) else $error("k not parked");
   a_clock_pairs: assert property (sram_out.k_n == !sram_out.k &&
      sram_out.c == (SINGLE_CLOCK_MODE | sram_out.k) &&
      sram_out.c_n == (SINGLE_CLOCK_MODE | !sram_out.k)) else $error("clock pair pins disagree");
endmodule : sram_port_host_monitor

bind sram_port_host sram_port_host_monitor sram_port_host_monitor_inst (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link_ready_out(link_ready_out),
   .clock_stopped_out(clock_stopped_out), .rd_valid_in(rd_valid_in), .rd_addr_in(rd_addr_in),
   .rd_ready_out(rd_ready_out), .rd_resp_valid_out(rd_resp_valid_out),
   .wr_valid_in(wr_valid_in), .wr_req_in(wr_req_in), .wr_ready_out(wr_ready_out),
   .sram_out(sram_out));

// ---- testbench/sram_device_model.sv ----
// behavioural burst sram seen from the host controller pins
`timescale 1ns/1ps
module sram_device_model (
   // pins from the host
   input wire sram_port_pkg::sram_pins_s sram_in,
   // echo clock and read data back
   output logic echo_clock_out,
   output sram_port_pkg::word_t read_data_out
);
   import sram_port_pkg::*;
   sram_pins_s held;
   word_t mem[int];
   int wr_at[int];
   int rd_at[int];
   int edge_no = 0;
   int last_rd = -9;
   int last_wr = -9;
   logic k_dly = 1'b0;
   logic osc = 1'b0;
   realtime last_k = 0.0;

   initial read_data_out = '0;
   // pins as seen just before each edge, so a same-edge change is not taken
   always @(sram_in) held <= #1 sram_in;

   // one step per k edge: commands at rises, beats on both edges
   always @(posedge sram_in.k or negedge sram_in.k) begin
      int a;
      edge_no++;
      last_k = $realtime;
      if (wr_at.exists(edge_no)) begin
         a = wr_at[edge_no];
         for (int l = 0; l < LANES; l++) begin
            if (!held.byte_write_select_n[l]) mem[a][l*LANE_W +: LANE_W] = held.write_data[l*LANE_W +: LANE_W];
         end
         wr_at.delete(edge_no);
      end
      // data outside a scheduled beat never reaches memory
      if (rd_at.exists(edge_no)) begin
         read_data_out <= #1 mem[rd_at[edge_no]];
         rd_at.delete(edge_no);
      end else begin
         read_data_out <= #1 ~read_data_out;
      end
      // separate schedules keep the two ports independent
      if (sram_in.k === 1'b1 && !held.read_select_n && edge_no - last_rd > 2) begin
         last_rd = edge_no;
         for (int i = 0; i < BURST_LEN; i++) rd_at[edge_no + 3 + i] = int'(held.shared_address_bus) + i;
      end
      if (sram_in.k === 1'b1 && !held.write_select_n && edge_no - last_wr > 2) begin
         last_wr = edge_no;
         for (int i = 0; i < BURST_LEN; i++) wr_at[edge_no + 2 + i] = int'(held.shared_address_bus) + i;
      end
   end

   // echo follows k, runs free while k is parked so its domain keeps clocking
   always @(sram_in.k) k_dly <= #3 (sram_in.k === 1'b1);
   always #3 if ($realtime - last_k > 50.0 || osc) osc = ~osc;
   assign echo_clock_out = k_dly ^ osc;
endmodule : sram_device_model

// ---- testbench/sram_port_host_test.sv ----
// self-checking bench for the burst sram host controller
`timescale 1ns/1ps
module sram_port_host_test;
   import sram_port_pkg::*;
   logic ref_clk_in, rst_in, clock_stop_req_in, dll_reset_req_in, link_ready_out;
   logic clock_stopped_out, rd_valid_in, rd_ready_out, rd_resp_valid_out;
   logic wr_valid_in, wr_ready_out, echo_clock_in;
   logic [ADDR_W-1:0] rd_addr_in;
   burst_t rd_data_out;
   wr_req_s wr_req_in;
   sram_pins_s sram_out;
   word_t read_data_in;
   burst_t resp_q[$];
   int mismatches, cmp_count, waited, k_rises;

   sram_port_host sram_port_host_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .clock_stop_req_in(clock_stop_req_in), .dll_reset_req_in(dll_reset_req_in),
      .link_ready_out(link_ready_out), .clock_stopped_out(clock_stopped_out),
      .rd_valid_in(rd_valid_in), .rd_addr_in(rd_addr_in), .rd_ready_out(rd_ready_out),
      .rd_resp_valid_out(rd_resp_valid_out), .rd_data_out(rd_data_out),
      .wr_valid_in(wr_valid_in), .wr_req_in(wr_req_in), .wr_ready_out(wr_ready_out),
      .sram_out(sram_out), .echo_clock_in(echo_clock_in), .read_data_in(read_data_in));
   sram_device_model sram_device_model_inst (.sram_in(sram_out),
      .echo_clock_out(echo_clock_in), .read_data_out(read_data_in));

   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   // answers pulse one cycle, so collect them mid-cycle
   always @(negedge ref_clk_in) begin
      if (rd_resp_valid_out === 1'b1) resp_q.push_back(rd_data_out);
   end
   // restart waits are stated in k cycles, so count k rises, not ref cycles
   always @(posedge sram_out.k) k_rises++;

   task automatic check(input string what, input logic [143:0] seen, input logic [143:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic close_out();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   // bounded wait at falling edges; cycles spent left in waited
   task automatic wait_for(ref logic sig, input int limit, input string what);
      for (waited = 0; waited < limit && sig !== 1'b1; waited++) @(negedge ref_clk_in);
      check(what, 144'(waited < limit), 144'(1));
   endtask : wait_for

   function automatic burst_t pat(input int s);
      burst_t b;
      for (int i = 0; i < BURST_LEN; i++) b[i] = 36'(s * 16 + i) ^ 36'h5_a5a5_a5a5;
      return b;
   endfunction : pat

   function automatic word_t merge(input word_t o, input word_t w, input logic [LANES-1:0] m);
      for (int l = 0; l < LANES; l++) if (!m[l]) o[l*LANE_W +: LANE_W] = w[l*LANE_W +: LANE_W];
      return o;
   endfunction : merge

   // request held until the ready pulse has been taken
   task automatic do_write(input logic [ADDR_W-1:0] a, input burst_t d, input logic [15:0] bw);
      wr_req_in = '{addr: a, data: d, byte_write_select_n: bw};
      wr_valid_in = 1'b1;
      wait_for(wr_ready_out, 40, "wr_ready_out");
      @(negedge ref_clk_in);
      wr_valid_in = 1'b0;
      // let an edge pass so a following write does not re-raise valid at once
      @(negedge ref_clk_in);
   endtask : do_write

   task automatic do_read(input logic [ADDR_W-1:0] a, output burst_t d);
      rd_addr_in = a;
      rd_valid_in = 1'b1;
      wait_for(rd_ready_out, 40, "rd_ready_out");
      @(negedge ref_clk_in);
      rd_valid_in = 1'b0;
      for (int n = 0; n < 60 && resp_q.size() == 0; n++) @(negedge ref_clk_in);
      d = (resp_q.size() > 0) ? resp_q.pop_front() : '0;
   endtask : do_read

   // two bursts back to back in consecutive write slots
   task automatic t_burst_pair();
      burst_t d;
      do_write(19'h0_0100, pat(1), 16'h0000);
      do_write(19'h0_0104, pat(2), 16'h0000);
      do_read(19'h0_0100, d);
      check("burst_a", d, pat(1));
      do_read(19'h0_0104, d);
      check("burst_b", d, pat(2));
   endtask : t_burst_pair

   // each lane alone, then no lane at all
   task automatic t_lanes();
      burst_t e, d, w;
      logic [LANES-1:0] m;
      e = pat(1);
      for (int l = 0; l <= LANES; l++) begin
         m = ~(4'h1 << l);
         w = pat(10 + l);
         do_write(19'h0_0100, w, {BURST_LEN{m}});
         for (int i = 0; i < BURST_LEN; i++) e[i] = merge(e[i], w[i], m);
         do_read(19'h0_0100, d);
         check("lane_merge", d, e);
      end
   endtask : t_lanes

   // park k, hold it, then restart or relock and confirm memory survived
   task automatic t_stop(input logic relock);
      burst_t d;
      int need;
      int k_from;
      need = relock ? LOCK_K_CYC + ZQ_NONREAD_K_CYC : RESTART_K_CYC;
      k_from = 0;
      clock_stop_req_in = ~relock;
      dll_reset_req_in = relock;
      wait_for(clock_stopped_out, 400, "clock_stopped_out");
      repeat (3) begin
         check("k_parked", 144'(sram_out.k), 144'(0));
         @(negedge ref_clk_in);
      end
      clock_stop_req_in = 1'b0;
      dll_reset_req_in = 1'b0;
      k_from = k_rises;
      wait_for(link_ready_out, 16000, "link_ready_out");
      check("restart_wait", 144'(k_rises - k_from >= need), 144'(1));
      do_read(19'h0_0104, d);
      check("after_restart", d, pat(2));
   endtask : t_stop

   initial begin
      rst_in = 1'b1;
      clock_stop_req_in = 1'b0;
      dll_reset_req_in = 1'b0;
      rd_valid_in = 1'b0;
      rd_addr_in = '0;
      wr_valid_in = 1'b0;
      wr_req_in = '0;
      mismatches = 0;
      cmp_count = 0;
      repeat (10) @(negedge ref_clk_in);
      rst_in = 1'b0;
      wait_for(link_ready_out, 16000, "link_ready_out");
      check("lock_wait", 144'(waited >= (LOCK_K_CYC + ZQ_NONREAD_K_CYC) * K_DIV), 144'(1));
      t_burst_pair();
      t_lanes();
      t_stop(1'b0);
      t_stop(1'b1);
      close_out();
   end

   // watchdog well beyond the longest expected run
   initial begin
      #1400000;
      mismatches++;
      close_out();
   end
endmodule : sram_port_host_test
